// ---- include/i2tm_pkg.sv ----
package i2tm_pkg;

  // register port
  localparam int          ADDR_W     = 3;
  localparam int          DATA_W     = 8;
  localparam logic [2:0]  OFS_TOC    = 3'h0;
  localparam logic [2:0]  OFS_STAT   = 3'h1;
  localparam logic [2:0]  OFS_CLR    = 3'h2;
  localparam logic [2:0]  OFS_IEN    = 3'h3;
  localparam logic [2:0]  OFS_SC1    = 3'h4;

  // time-out control fields
  localparam int          TOEN_BIT   = 7;
  localparam int          TOF_BIT    = 6;
  localparam int          SEL_W      = 6;
  localparam int          SEL_LSB    = 0;
  localparam logic [7:0]  TOC_RST    = 8'h00;

  // serial control one fields
  localparam int          SC1_AM_BIT = 6;
  localparam int          SC1_BB_BIT = 5;
  localparam logic [7:0]  SC1_RST    = 8'h01;
  localparam logic [7:0]  SC1_WMASK  = 8'h1f;

  // interrupt status bits
  localparam int          IRQ_W      = 2;
  localparam int          IRQ_TO     = 0;
  localparam int          IRQ_AM     = 1;

  // tick divider and counter width
  localparam int          PRESCALE   = 32;
  localparam int          CNT_W      = 12;

  typedef enum logic [0:0] {
    MON_IDLE = 1'b0,
    MON_RUN  = 1'b1
  } i2tm_state_t;

endpackage

// ---- rtl/i2tm_monitor.sv ----
module i2tm_monitor #(
  parameter int PRESCALE = i2tm_pkg::PRESCALE
) (
  // clock, reset, enable
  input  wire logic                          clk_in,
  input  wire logic                          nrst_in,
  input  wire logic                          clk_en_in,
  // bus pins and subclock, asynchronous
  input  wire logic                          scl_in,
  input  wire logic                          sda_in,
  input  wire logic                          subclk_in,
  // from the slave address comparator
  input  wire logic                          addr_match_in,
  // register port
  input  wire logic [i2tm_pkg::ADDR_W-1:0]   reg_addr_in,
  input  wire logic [i2tm_pkg::DATA_W-1:0]   reg_wdata_in,
  input  wire logic                          reg_wr_in,
  input  wire logic                          reg_rd_in,
  output logic      [i2tm_pkg::DATA_W-1:0]   reg_rdata_out,
  // to the rest of the I2C slave
  output logic                               i2c_reset_out,
  output logic                               irq_out
);

  localparam int CW = i2tm_pkg::CNT_W;

  function automatic logic [CW-1:0] period_of(
    input logic [i2tm_pkg::SEL_W-1:0] sel
  );
    logic [CW-1:0] p;
    p = CW'(sel) + CW'(1);
    period_of = CW'(p * CW'(PRESCALE));
  endfunction

  function automatic logic hit(
    input logic [i2tm_pkg::ADDR_W-1:0] a,
    input logic [i2tm_pkg::ADDR_W-1:0] ofs
  );
    hit = (a == ofs);
  endfunction

  // pin synchronisers: bit 0 scl, bit 1 sda, bit 2 subclock
  logic [2:0]                 pin_s1_ff;
  logic [2:0]                 pin_s2_ff;
  logic [2:0]                 pin_d_ff;
  logic                       start_det;
  logic                       stop_det;
  logic                       scl_fall;
  logic                       sub_rise;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_s1_ff <= 3'h3;
      pin_s2_ff <= 3'h3;
      pin_d_ff  <= 3'h3;
    end else if (clk_en_in) begin
      pin_s1_ff <= {subclk_in, sda_in, scl_in};
      pin_s2_ff <= pin_s1_ff;
      pin_d_ff  <= pin_s2_ff;
    end
  end

  // both scl samples high so a slow SCL edge is not taken as START
  assign start_det = pin_s2_ff[0] && pin_d_ff[0] && pin_d_ff[1] && !pin_s2_ff[1];
  assign stop_det  = pin_s2_ff[0] && pin_d_ff[0] && !pin_d_ff[1] && pin_s2_ff[1];
  assign scl_fall  = pin_d_ff[0] && !pin_s2_ff[0];
  assign sub_rise  = !pin_d_ff[2] && pin_s2_ff[2];

  // register write decode
  logic                       wr_toc;
  logic                       wr_clr;
  logic                       wr_ien;
  logic                       wr_sc1;

  assign wr_toc = clk_en_in && reg_wr_in && hit(reg_addr_in, i2tm_pkg::OFS_TOC);
  assign wr_clr = clk_en_in && reg_wr_in && hit(reg_addr_in, i2tm_pkg::OFS_CLR);
  assign wr_ien = clk_en_in && reg_wr_in && hit(reg_addr_in, i2tm_pkg::OFS_IEN);
  assign wr_sc1 = clk_en_in && reg_wr_in && hit(reg_addr_in, i2tm_pkg::OFS_SC1);

  // time-out control register
  logic                       toen_ff;
  logic                       tof_ff;
  logic [i2tm_pkg::SEL_W-1:0] sel_ff;
  logic                       to_hit;

  // monitor state
  i2tm_pkg::i2tm_state_t      st_ff;
  logic                       armed_ff;
  logic [CW-1:0]              cnt_ff;

  // counter reaching the period before the next fall is the overflow
  assign to_hit = clk_en_in && st_ff == i2tm_pkg::MON_RUN && !stop_det && !scl_fall
                  && sub_rise && cnt_ff == period_of(sel_ff) - CW'(1);

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sel_ff <= i2tm_pkg::TOC_RST[i2tm_pkg::SEL_LSB +: i2tm_pkg::SEL_W];
    end else if (wr_toc) begin
      sel_ff <= reg_wdata_in[i2tm_pkg::SEL_LSB +: i2tm_pkg::SEL_W];
    end
  end

  // hardware clear of the enable wins over a write in the same cycle
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      toen_ff <= i2tm_pkg::TOC_RST[i2tm_pkg::TOEN_BIT];
    end else if (to_hit) begin
      toen_ff <= 1'b0;
    end else if (wr_toc) begin
      toen_ff <= reg_wdata_in[i2tm_pkg::TOEN_BIT];
    end
  end

  // writing zero clears; writing one leaves it; a new time-out wins
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tof_ff <= i2tm_pkg::TOC_RST[i2tm_pkg::TOF_BIT];
    end else if (to_hit) begin
      tof_ff <= 1'b1;
    end else if (wr_toc && !reg_wdata_in[i2tm_pkg::TOF_BIT]) begin
      tof_ff <= 1'b0;
    end
  end

  // START arms the monitor, an address match then starts it
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      armed_ff <= 1'b0;
    end else if (clk_en_in) begin
      if (stop_det || to_hit) begin
        armed_ff <= 1'b0;
      end else if (start_det) begin
        armed_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_ff <= i2tm_pkg::MON_IDLE;
    end else if (clk_en_in) begin
      case (st_ff)
        i2tm_pkg::MON_IDLE: begin
          if (!stop_det && toen_ff && addr_match_in && (armed_ff || start_det)) begin
            st_ff <= i2tm_pkg::MON_RUN;
          end
        end
        i2tm_pkg::MON_RUN: begin
          if (stop_det || to_hit || !toen_ff) begin
            st_ff <= i2tm_pkg::MON_IDLE;
          end
        end
        default: begin
          st_ff <= i2tm_pkg::MON_IDLE;
        end
      endcase
    end
  end

  // counts subclock rising edges; an SCL fall zeroes it so each bit starts fresh
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_ff <= '0;
    end else if (clk_en_in) begin
      if (st_ff != i2tm_pkg::MON_RUN || scl_fall || to_hit) begin
        cnt_ff <= '0;
      end else if (sub_rise) begin
        cnt_ff <= cnt_ff + CW'(1);
      end
    end
  end

  // one-cycle reset of the I2C engine; data, address, control zero untouched
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      i2c_reset_out <= 1'b0;
    end else if (clk_en_in) begin
      i2c_reset_out <= to_hit;
    end
  end

  // serial control one: match and busy flags by hardware, low bits by software
  logic [i2tm_pkg::DATA_W-1:0] sc1_ff;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sc1_ff <= i2tm_pkg::SC1_RST;
    end else if (to_hit) begin
      sc1_ff <= i2tm_pkg::SC1_RST;
    end else if (clk_en_in) begin
      if (wr_sc1) begin
        sc1_ff <= (sc1_ff & ~i2tm_pkg::SC1_WMASK) | (reg_wdata_in & i2tm_pkg::SC1_WMASK);
      end
      if (start_det) begin
        sc1_ff[i2tm_pkg::SC1_BB_BIT] <= 1'b1;
        sc1_ff[i2tm_pkg::SC1_AM_BIT] <= 1'b0;
      end else if (stop_det) begin
        sc1_ff[i2tm_pkg::SC1_BB_BIT] <= 1'b0;
        sc1_ff[i2tm_pkg::SC1_AM_BIT] <= 1'b0;
      end else if (addr_match_in) begin
        sc1_ff[i2tm_pkg::SC1_AM_BIT] <= 1'b1;
      end
    end
  end

  // interrupt status, enable and write-one-to-clear
  logic [i2tm_pkg::IRQ_W-1:0] stat_ff;
  logic [i2tm_pkg::IRQ_W-1:0] ien_ff;
  logic [i2tm_pkg::IRQ_W-1:0] ev_set;
  logic [i2tm_pkg::IRQ_W-1:0] ev_clr;

  always_comb begin
    ev_set = '0;
    ev_set[i2tm_pkg::IRQ_TO] = to_hit;
    ev_set[i2tm_pkg::IRQ_AM] = clk_en_in && addr_match_in;
    ev_clr = wr_clr ? reg_wdata_in[i2tm_pkg::IRQ_W-1:0] : '0;
  end

  // set wins so an event in the clearing cycle is kept
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stat_ff <= '0;
    end else begin
      stat_ff <= (stat_ff & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ien_ff <= '0;
    end else if (wr_ien) begin
      ien_ff <= reg_wdata_in[i2tm_pkg::IRQ_W-1:0];
    end
  end

  // one vector for match and time-out events
  assign irq_out = |(stat_ff & ien_ff);

  // read data valid only in the cycle after the strobe
  logic [i2tm_pkg::DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    case (reg_addr_in)
      i2tm_pkg::OFS_TOC: begin
        rd_mux = {toen_ff, tof_ff, sel_ff};
      end
      i2tm_pkg::OFS_STAT: begin
        rd_mux = {{(i2tm_pkg::DATA_W-i2tm_pkg::IRQ_W){1'b0}}, stat_ff};
      end
      i2tm_pkg::OFS_IEN: begin
        rd_mux = {{(i2tm_pkg::DATA_W-i2tm_pkg::IRQ_W){1'b0}}, ien_ff};
      end
      i2tm_pkg::OFS_SC1: begin
        rd_mux = sc1_ff;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= '0;
    end else if (clk_en_in) begin
      reg_rdata_out <= reg_rd_in ? rd_mux : '0;
    end
  end

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_to_event;
    to_hit;
  endsequence

  sequence s_to_after;
    !toen_ff && tof_ff && st_ff == i2tm_pkg::MON_IDLE && cnt_ff == '0;
  endsequence

  // the match may come several cycles after START; armed_ff says no STOP came between
  sequence s_armed_match;
    clk_en_in && start_det ##[1:40] clk_en_in && armed_ff && !stop_det && toen_ff
      && addr_match_in && st_ff == i2tm_pkg::MON_IDLE;
  endsequence

  start_monitor_a: assert property (
    s_armed_match |=> st_ff == i2tm_pkg::MON_RUN
  ) else $error("monitor did not start after START and match");

  scl_clear_a: assert property (
    clk_en_in && st_ff == i2tm_pkg::MON_RUN && scl_fall |=> cnt_ff == '0
  ) else $error("counter not cleared by SCL fall");

  count_bound_a: assert property (
    cnt_ff < period_of(sel_ff) || $changed(sel_ff)
  ) else $error("counter passed the selected period");

  timeout_seq_a: assert property (
    s_to_event |=> s_to_after
  ) else $error("time-out did not stop, disable and flag");

  stop_halt_a: assert property (
    clk_en_in && stop_det |=> st_ff == i2tm_pkg::MON_IDLE ##1 st_ff == i2tm_pkg::MON_IDLE
  ) else $error("monitoring not halted by STOP");

  timeout_irq_a: assert property (
    to_hit && ien_ff[i2tm_pkg::IRQ_TO] && !wr_ien |=> irq_out && i2c_reset_out
  ) else $error("time-out raised no interrupt or reset");

  sc1_reset_a: assert property (
    to_hit |=> sc1_ff == i2tm_pkg::SC1_RST
  ) else $error("serial control one not reset by time-out");

  flag_hold_a: assert property (
    tof_ff && !(wr_toc && !reg_wdata_in[i2tm_pkg::TOF_BIT]) |=> tof_ff
  ) else $error("time-out flag lost without a clear");

  flag_read_a: assert property (
    clk_en_in && reg_rd_in && reg_addr_in == i2tm_pkg::OFS_TOC
      |=> reg_rdata_out[i2tm_pkg::TOF_BIT] == $past(tof_ff)
  ) else $error("read of time-out flag wrong");

  busy_set_a: assert property (
    clk_en_in && start_det && !to_hit |=> sc1_ff[i2tm_pkg::SC1_BB_BIT]
  ) else $error("bus busy not set by START");

endmodule

// ---- tb/i2tm_bus_master.sv ----
module i2tm_bus_master (
  // clock
  input  wire logic clk_in,
  // bus lines, driven high directly by the master when released
  output logic      scl_out,
  output logic      sda_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // lines are raised first so a repeated start works from any state
  task automatic bus_start();
    @(posedge clk_in) sda_out <= 1'b1;
    hold(4);
    scl_out <= 1'b1;
    hold(4);
    sda_out <= 1'b0;
    hold(4);
    scl_out <= 1'b0;
    hold(4);
  endtask

  // only legal after a start, when clock is already low
  task automatic bus_stop();
    @(posedge clk_in) sda_out <= 1'b0;
    hold(4);
    scl_out <= 1'b1;
    hold(4);
    sda_out <= 1'b1;
    hold(4);
  endtask

  // four cycles per phase, longer than the pin synchroniser needs
  task automatic clock_pulse();
    @(posedge clk_in) scl_out <= 1'b1;
    hold(4);
    scl_out <= 1'b0;
    hold(3);
  endtask
endmodule

// ---- tb/test_i2c_slave_timeout_monitor.sv ----
module test_i2c_slave_timeout_monitor;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int PS = 2;

  logic       clk_in = 1'b0;
  logic       nrst_in;
  logic       clk_en;
  logic       addr_match;
  logic       wr;
  logic       rd;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic [2:0] sub_div = 3'h0;
  wire  [7:0] rdata;
  wire        i2c_rst;
  wire        irq;
  wire        scl;
  wire        sda;
  int         rises = 0;
  int         num_errors;
  int         total_checks;

  always #20 clk_in = ~clk_in;

  // subclock is eight system cycles long; rises are counted as they are launched
  always @(posedge clk_in) begin
    sub_div <= sub_div + 3'h1;
    if (sub_div == 3'h3) rises <= rises + 1;
  end

  i2tm_monitor #(.PRESCALE(PS)) dut (
    .clk_in        (clk_in),
    .nrst_in       (nrst_in),
    .clk_en_in     (clk_en),
    .scl_in        (scl),
    .sda_in        (sda),
    .subclk_in     (sub_div[2]),
    .addr_match_in (addr_match),
    .reg_addr_in   (addr),
    .reg_wdata_in  (wdata),
    .reg_wr_in     (wr),
    .reg_rd_in     (rd),
    .reg_rdata_out (rdata),
    .i2c_reset_out (i2c_rst),
    .irq_out       (irq)
  );

  i2tm_bus_master m (
    .clk_in  (clk_in),
    .scl_out (scl),
    .sda_out (sda)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_in);
    wr    <= 1'b0;
  endtask

  task automatic expect_reg(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_in);
    rd   <= 1'b0;
    #1 check(rdata, exp);
  endtask

  task automatic match();
    @(posedge clk_in) addr_match <= 1'b1;
    @(posedge clk_in) addr_match <= 1'b0;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic run_timeout(input logic [5:0] sel, input logic [7:0] ien, input logic exp_irq);
    int base;
    int n;
    int k;
    n = (int'(sel) + 1) * PS;
    wr_reg(i2tm_pkg::OFS_SC1, 8'h1f);
    wr_reg(i2tm_pkg::OFS_IEN, ien);
    wr_reg(i2tm_pkg::OFS_TOC, {2'b10, sel});
    m.bus_start();
    expect_reg(i2tm_pkg::OFS_SC1, 8'h3f);
    match();
    expect_reg(i2tm_pkg::OFS_SC1, 8'h7f);
    // clock falls closer together than any period keep the count from expiring
    repeat (6) m.clock_pulse();
    expect_reg(i2tm_pkg::OFS_TOC, {2'b10, sel});
    base = rises;
    for (k = 0; k < 3000 && i2c_rst !== 1'b1; k++) @(posedge clk_in) #1;
    check({7'h0, (rises - base >= n - 1) && (rises - base <= n)}, 8'h01);
    check({7'h0, irq}, {7'h0, exp_irq});
    @(posedge clk_in) #1 check({7'h0, i2c_rst}, 8'h00);
    expect_reg(i2tm_pkg::OFS_TOC, {2'b01, sel});
    expect_reg(i2tm_pkg::OFS_SC1, 8'h01);
    expect_reg(i2tm_pkg::OFS_STAT, 8'h03);
    wr_reg(i2tm_pkg::OFS_IEN, 8'h01);
    #1 check({7'h0, irq}, 8'h01);
    wr_reg(i2tm_pkg::OFS_TOC, {2'b01, sel});
    expect_reg(i2tm_pkg::OFS_TOC, {2'b01, sel});
    wr_reg(i2tm_pkg::OFS_TOC, {2'b00, sel});
    expect_reg(i2tm_pkg::OFS_TOC, {2'b00, sel});
    wr_reg(i2tm_pkg::OFS_CLR, 8'h03);
    #1 check({7'h0, irq}, 8'h00);
    m.bus_stop();
    $display("time-out run with select %h done", sel);
  endtask

  initial begin
    nrst_in      = 1'b0;
    addr_match   = 1'b0;
    wr           = 1'b0;
    rd           = 1'b0;
    addr         = 3'h0;
    wdata        = 8'h00;
    clk_en       = 1'b1;
    num_errors   = 0;
    total_checks = 0;
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    expect_reg(i2tm_pkg::OFS_TOC, 8'h00);
    expect_reg(i2tm_pkg::OFS_SC1, 8'h01);
    expect_reg(i2tm_pkg::OFS_IEN, 8'h00);
    wr_reg(i2tm_pkg::OFS_STAT, 8'hff);
    expect_reg(i2tm_pkg::OFS_STAT, 8'h00);
    expect_reg(i2tm_pkg::OFS_CLR, 8'h00);
    expect_reg(3'h5, 8'h00);
    $display("reset values done");
    run_timeout(6'h00, 8'h00, 1'b0);
    run_timeout(6'h05, 8'h01, 1'b1);
    run_timeout(6'h3f, 8'h01, 1'b1);
    // enabled but no start and match: counter must not run
    // period of 96 cycles: longer than start-to-stop, shorter than the idle waits
    wr_reg(i2tm_pkg::OFS_TOC, 8'h85);
    repeat (200) @(posedge clk_in);
    expect_reg(i2tm_pkg::OFS_TOC, 8'h85);
    m.bus_start();
    match();
    m.bus_stop();
    repeat (200) @(posedge clk_in);
    expect_reg(i2tm_pkg::OFS_TOC, 8'h85);
    wr_reg(i2tm_pkg::OFS_TOC, 8'h00);
    m.bus_start();
    match();
    repeat (200) @(posedge clk_in);
    expect_reg(i2tm_pkg::OFS_TOC, 8'h00);
    m.bus_stop();
    // a write while the clock enable is low must be ignored
    @(posedge clk_in) clk_en <= 1'b0;
    wr_reg(i2tm_pkg::OFS_TOC, 8'hbf);
    clk_en <= 1'b1;
    expect_reg(i2tm_pkg::OFS_TOC, 8'h00);
    $display("halt and disable done");
    print_verdict();
  end

  initial begin
    #(40 * 30000);
    num_errors++;
    print_verdict();
  end
endmodule
